// ==== common/alarm_pkg.sv ====
// Package for the alarm and event monitor: register map, fields, types, timing.
package alarm_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ACK = 8'h08;
  localparam logic [7:0] OFS_OVP_LIM = 8'h0C;
  localparam logic [7:0] OFS_OCP_LIM = 8'h10;
  localparam logic [7:0] OFS_OPP_LIM = 8'h14;
  localparam logic [7:0] OFS_EVT_BASE = 8'h20;
  localparam logic [7:0] OFS_PROF_SEL = 8'h40;
  localparam logic [7:0] OFS_PIN = 8'h44;
  localparam logic [7:0] OFS_PIN_ENTRY = 8'h48;
  localparam logic [7:0] OFS_LOCK_STAT = 8'h4C;
  localparam logic [7:0] OFS_EVT_STAT = 8'h50;
  localparam logic [7:0] OFS_PROF_SAVE = 8'h54;

  // ---------------------------------------------------------------
  // Widths and sizes
  // ---------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int NUM_EVT = 5;
  localparam int NUM_PROF = 6;
  localparam int NUM_ALM = 6;

  // Nominal values, arbitrary scale
  localparam logic [VAL_W-1:0] U_NOM = 16'hE8BA;
  localparam logic [VAL_W-1:0] I_NOM = 16'hE8BA;
  localparam logic [VAL_W-1:0] P_NOM = 16'hE8BA;
  // Protection default 110 % and upper limit 1.1 * nominal
  localparam logic [VAL_W-1:0] PROT_DEFAULT = 16'hFFFF;
  localparam logic [VAL_W-1:0] PROT_MAX = 16'hFFFF;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_SOUND = 0;
  localparam int CTRL_OT_AUTO = 1;
  localparam int CTRL_LOCK_EN = 2;
  localparam int CTRL_LOCK_ONOFF = 3;
  localparam int CTRL_PIN_EN = 4;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // Alarm bit positions
  localparam int ALM_OVP = 0;
  localparam int ALM_OCP = 1;
  localparam int ALM_OPP = 2;
  localparam int ALM_SUPPLY = 3;
  localparam int ALM_OT = 4;
  localparam int ALM_PAR = 5;

  // Event index
  localparam int EV_LOW_U = 0;
  localparam int EV_HIGH_U = 1;
  localparam int EV_LOW_I = 2;
  localparam int EV_HIGH_I = 3;
  localparam int EV_HIGH_P = 4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int UNLOCK_WINDOW_MS = 5000;
  localparam int UNLOCK_CYCLES = UNLOCK_WINDOW_MS * CLK_MHZ * 1000;
  localparam int TMR_W = 30;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_SIGNAL,
    ACT_WARNING,
    ACT_ALARM
  } action_type;

  typedef struct packed {
    logic [VAL_W-1:0] limit;
    action_type action;
  } event_cfg_type;

  typedef struct packed {
    logic [VAL_W-1:0] voltage;
    logic [VAL_W-1:0] current;
    logic [VAL_W-1:0] power;
  } meas_type;

  typedef enum logic [1:0] {
    LK_OPEN,
    LK_LOCKED,
    LK_REQUEST,
    LK_PIN_WAIT
  } lock_state_type;
endpackage

// ==== design/alarm_event_monitor.sv ====
// Alarm latching, user events, output switch-off and front-panel lock.
// Notes on behaviour
// (RL1) Alarms stay pending until acknowledged, even after the cause is gone.
// (RL2) Still-present alarm after acknowledge stays shown and can be re-raised.
// (RL3) Current at overcurrent limit raises alarm and switches output off.
// (RL4) Power at overpower limit raises alarm, switches off; limit up to 1.1 nominal.
// (RL5) Protection limits reset to 110 percent of nominal.
// (RL6) Overtemperature raises alarm, switches off; auto restore is configurable.
// (RL7) Lost parallel slave raises alarm and switches off until reinitialised.
// (RL8) All user events reset with action none.
// (RL9) Events are evaluated only while the output is on.
// (RL10) Five events, each with own limit and action none/signal/warning/alarm.
// (RL11) Low-voltage event fires below its limit, limit up to nominal.
// (RL12) High-voltage event fires above its limit, limit up to nominal.
// (RL13) Low-current event fires below its limit, limit up to nominal.
// (RL14) High-current event fires above its limit, limit up to nominal.
// (RL15) High-power event fires above its limit, limit up to nominal.
// (RL16) Event with alarm action switches the output off.
// (RL17) Event settings are stored per profile; selecting one loads it.
// (RL18) Sound on alarms only when the sound enable is set.
// (RL19) While locked, value changes are rejected and raise an unlock request.
// (RL20) Lock may be full or leave the on/off button usable.
// (RL21) Unlock request must be confirmed within 5 s or it is withdrawn.
// (RL22) With PIN enabled every unlock needs the correct PIN.
// (RL23) Alarm action: status text, alarm notice, sound if enabled, output off.
// (RL24) Warning action adds a warning notice; signal shows only status text.
// (RL25) Each alarm and event is a latched flag cleared only by acknowledge; the parallel alarm clears only on reinit.
// (RL26) Unlock timeout counted in clock cycles from a five-second parameter.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module alarm_event_monitor
  import alarm_pkg::*;
#(
  parameter int UNLOCK_TICKS = UNLOCK_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Power stage side
  input wire meas_type MEAS,
  input wire logic OUTPUT_ON_REQ,
  input wire logic SUPPLY_FAIL,
  input wire logic TEMP_LIMIT,
  input wire logic SLAVE_LOST,
  input wire logic PARALLEL_REINIT,
  output logic OUTPUT_ENABLE,
  // Front panel side
  input wire logic PANEL_CHANGE,
  input wire logic PANEL_ONOFF,
  input wire logic PANEL_CONFIRM,
  input wire logic PANEL_STATUS_TAP,
  input wire logic PANEL_ACK,
  output logic PANEL_ACCEPT,
  output logic PANEL_ONOFF_ACCEPT,
  output logic UNLOCK_REQUEST,
  output logic PIN_REQUEST,
  output logic ALARM_NOTICE,
  output logic WARNING_NOTICE,
  output logic SOUND,
  output logic [NUM_ALM-1:0] ALARM_FLAGS,
  output logic [NUM_EVT-1:0] EVENT_FLAGS,
  output logic [2:0] ANALOG_ALARMS
);
  // ---------------------------------------------------------------
  // Configuration storage
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [VAL_W-1:0] ovp_lim, ocp_lim, opp_lim;
  event_cfg_type evt_cfg [NUM_EVT];
  event_cfg_type prof_mem [NUM_PROF][NUM_EVT];
  logic [2:0] prof_sel;
  logic [15:0] pin_code;
  logic [NUM_ALM-1:0] alarm_latch, alarm_seen;
  logic [NUM_EVT-1:0] event_latch;
  logic output_on;
  logic alarm_pop, warn_pop;
  lock_state_type lock_state;
  logic [TMR_W-1:0] unlock_timer;
  logic pin_ok;

  function automatic logic [VAL_W-1:0] clamp(input logic [VAL_W-1:0] v,
                                            input logic [VAL_W-1:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite handshake
  // ---------------------------------------------------------------
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire have_aw = aw_hold || aw_take;
  wire have_w = w_hold || w_take;
  wire [7:0] wr_addr = aw_hold ? aw_addr : S_AXI_AWADDR;
  wire [31:0] wr_data = w_hold ? w_data : S_AXI_WDATA;
  wire wr_fire = have_aw && have_w && !S_AXI_BVALID;
  wire wr_full = S_AXI_WSTRB == 4'hF;
  wire wr_evt = wr_addr >= OFS_EVT_BASE && wr_addr < OFS_EVT_BASE + 8'(4 * NUM_EVT);
  wire [2:0] wr_idx = 3'((wr_addr - OFS_EVT_BASE) >> 2);
  wire wr_known = wr_evt || wr_addr == OFS_CTRL || wr_addr == OFS_ACK
    || wr_addr == OFS_OVP_LIM || wr_addr == OFS_OCP_LIM || wr_addr == OFS_OPP_LIM
    || wr_addr == OFS_PROF_SEL || wr_addr == OFS_PIN || wr_addr == OFS_PIN_ENTRY
    || wr_addr == OFS_PROF_SAVE;
  wire wr_ok = wr_fire && wr_full && wr_known;
  // Locked panel ignores config writes; ack and PIN entry still act
  wire wr_cfg = wr_ok && lock_state == LK_OPEN;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !have_aw && !S_AXI_AWREADY;
      S_AXI_WREADY <= !have_w && !S_AXI_WREADY;
      if (aw_take) aw_addr <= S_AXI_AWADDR;
      if (w_take) w_data <= S_AXI_WDATA;
      aw_hold <= have_aw && !wr_fire;
      w_hold <= have_w && !wr_fire;
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_full && wr_known) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  wire rd_evt = S_AXI_ARADDR >= OFS_EVT_BASE
    && S_AXI_ARADDR < OFS_EVT_BASE + 8'(4 * NUM_EVT);
  wire [2:0] rd_idx = 3'((S_AXI_ARADDR - OFS_EVT_BASE) >> 2);
  logic [31:0] rd_val;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    rd_val = 32'h0000_0000;
    if (rd_evt) begin
      rd_val = 32'({evt_cfg[rd_idx].action, evt_cfg[rd_idx].limit});
    end else begin
      case (S_AXI_ARADDR)
        OFS_CTRL: rd_val = 32'(ctrl);
        OFS_STATUS: rd_val = 32'({output_on, alarm_seen, alarm_latch});
        OFS_OVP_LIM: rd_val = 32'(ovp_lim);
        OFS_OCP_LIM: rd_val = 32'(ocp_lim);
        OFS_OPP_LIM: rd_val = 32'(opp_lim);
        OFS_PROF_SEL: rd_val = 32'(prof_sel);
        OFS_LOCK_STAT: rd_val = 32'(lock_state);
        OFS_EVT_STAT: rd_val = 32'(event_latch);
        OFS_ACK, OFS_PIN, OFS_PIN_ENTRY, OFS_PROF_SAVE: rd_val = 32'h0000_0000;
        default: rd_known = 1'b0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration writes and profile store
  // ---------------------------------------------------------------
  wire prof_load = wr_cfg && wr_addr == OFS_PROF_SEL && wr_data[2:0] < 3'(NUM_PROF);
  // Profile 0 is the read-only default
  wire prof_save = wr_cfg && wr_addr == OFS_PROF_SAVE && wr_data[2:0] != 3'h0
    && wr_data[2:0] < 3'(NUM_PROF);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      ovp_lim <= PROT_DEFAULT; // see RL5
      ocp_lim <= PROT_DEFAULT; // see RL5
      opp_lim <= PROT_DEFAULT; // see RL5
      prof_sel <= 3'h0;
      pin_code <= 16'h0000;
      for (int e = 0; e < NUM_EVT; e++) begin
        evt_cfg[e] <= '{limit: '0, action: ACT_NONE}; // see RL8
        for (int p = 0; p < NUM_PROF; p++) prof_mem[p][e] <= '{limit: '0, action: ACT_NONE};
      end
    end else begin
      if (wr_cfg && wr_addr == OFS_CTRL) ctrl <= wr_data[CTRL_W-1:0];
      if (wr_cfg && wr_addr == OFS_OVP_LIM) ovp_lim <= clamp(wr_data[VAL_W-1:0], PROT_MAX);
      if (wr_cfg && wr_addr == OFS_OCP_LIM) ocp_lim <= clamp(wr_data[VAL_W-1:0], PROT_MAX);
      if (wr_cfg && wr_addr == OFS_OPP_LIM) opp_lim <= clamp(wr_data[VAL_W-1:0], PROT_MAX); // see RL4
      if (wr_cfg && wr_addr == OFS_PIN) pin_code <= wr_data[15:0];
      if (wr_cfg && wr_evt) begin // see RL10
        evt_cfg[wr_idx].action <= action_type'(wr_data[VAL_W+1:VAL_W]);
        evt_cfg[wr_idx].limit <= clamp(wr_data[VAL_W-1:0],
          (wr_idx == 3'(EV_LOW_U) || wr_idx == 3'(EV_HIGH_U)) ? U_NOM :
          (wr_idx == 3'(EV_HIGH_P)) ? P_NOM : I_NOM); // see RL11
      end
      if (prof_load) begin // see RL17
        prof_sel <= wr_data[2:0];
        for (int e = 0; e < NUM_EVT; e++) evt_cfg[e] <= prof_mem[wr_data[2:0]][e];
      end
      if (prof_save) begin
        for (int e = 0; e < NUM_EVT; e++) prof_mem[wr_data[2:0]][e] <= evt_cfg[e];
      end
    end
  end

  // ---------------------------------------------------------------
  // Detection
  // ---------------------------------------------------------------
  logic [NUM_ALM-1:0] alarm_cond;
  assign alarm_cond[ALM_OVP] = MEAS.voltage >= ovp_lim;
  assign alarm_cond[ALM_OCP] = MEAS.current >= ocp_lim; // see RL3
  assign alarm_cond[ALM_OPP] = MEAS.power >= opp_lim; // see RL4
  assign alarm_cond[ALM_SUPPLY] = SUPPLY_FAIL;
  assign alarm_cond[ALM_OT] = TEMP_LIMIT; // see RL6
  assign alarm_cond[ALM_PAR] = SLAVE_LOST; // see RL7

  logic [NUM_EVT-1:0] evt_hit, evt_fire;
  assign evt_hit[EV_LOW_U] = MEAS.voltage < evt_cfg[EV_LOW_U].limit; // see RL11
  assign evt_hit[EV_HIGH_U] = MEAS.voltage > evt_cfg[EV_HIGH_U].limit; // see RL12
  assign evt_hit[EV_LOW_I] = MEAS.current < evt_cfg[EV_LOW_I].limit; // see RL13
  assign evt_hit[EV_HIGH_I] = MEAS.current > evt_cfg[EV_HIGH_I].limit; // see RL14
  assign evt_hit[EV_HIGH_P] = MEAS.power > evt_cfg[EV_HIGH_P].limit; // see RL15

  logic [NUM_EVT-1:0] evt_alarm, evt_warn;
  always_comb begin
    for (int e = 0; e < NUM_EVT; e++) begin
      // Output on and action set
      evt_fire[e] = output_on && evt_hit[e] && evt_cfg[e].action != ACT_NONE; // see RL9
      evt_alarm[e] = evt_cfg[e].action == ACT_ALARM;
      evt_warn[e] = evt_cfg[e].action == ACT_WARNING;
    end
  end

  // Panel acks all; register ack takes a mask
  wire [NUM_ALM-1:0] ack_alm = (PANEL_ACK ? {NUM_ALM{1'b1}} : '0)
    | ((wr_ok && wr_addr == OFS_ACK) ? wr_data[NUM_ALM-1:0] : '0);
  wire [NUM_EVT-1:0] ack_evt = (PANEL_ACK ? {NUM_EVT{1'b1}} : '0)
    | ((wr_ok && wr_addr == OFS_ACK) ? wr_data[NUM_ALM+NUM_EVT-1:NUM_ALM] : '0);
  // Link alarm clears only on reinit
  wire [NUM_ALM-1:0] alm_clear = {PARALLEL_REINIT, ack_alm[NUM_ALM-2:0]}; // see RL7

  wire [NUM_ALM-1:0] next_alarm_latch = (alarm_latch & ~alm_clear) | alarm_cond; // see RL1
  wire [NUM_EVT-1:0] next_event_latch = (event_latch & ~ack_evt) | evt_fire; // see RL25
  wire [NUM_ALM-1:0] rising_alm = alarm_cond & ~alarm_latch;
  wire any_alarm_evt = |(evt_fire & evt_alarm & ~event_latch);
  wire any_warn_evt = |(evt_fire & evt_warn & ~event_latch);
  wire new_alarm = |rising_alm || any_alarm_evt;
  // OT may return on its own when auto restore is set
  wire ot_block = alarm_latch[ALM_OT] && !(ctrl[CTRL_OT_AUTO] && !TEMP_LIMIT); // see RL6
  wire [NUM_ALM-1:0] no_ot = ~(NUM_ALM'(1) << ALM_OT);
  wire trip = |alarm_cond || |(evt_fire & evt_alarm); // see RL16

  // ---------------------------------------------------------------
  // Alarm latches, notices, output control
  // ---------------------------------------------------------------
  wire onoff_ok = lock_state == LK_OPEN || ctrl[CTRL_LOCK_ONOFF]; // see RL20
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      alarm_latch <= '0;
      alarm_seen <= '0;
      event_latch <= '0;
      output_on <= 1'b0;
      alarm_pop <= 1'b0;
      warn_pop <= 1'b0;
    end else begin
      alarm_latch <= next_alarm_latch; // see RL25
      event_latch <= next_event_latch;
      // Acked but present alarms stay shown
      alarm_seen <= (alarm_seen | (alarm_latch & ack_alm & alarm_cond)) & alarm_cond; // see RL2
      if (new_alarm) alarm_pop <= 1'b1; // see RL23
      else if (PANEL_STATUS_TAP && |alarm_seen) alarm_pop <= 1'b1; // see RL2
      else if (PANEL_ACK) alarm_pop <= 1'b0;
      if (any_warn_evt) warn_pop <= 1'b1; // see RL24
      else if (PANEL_ACK) warn_pop <= 1'b0;
      if (trip) output_on <= 1'b0; // see RL3
      else if (PANEL_ONOFF && onoff_ok && output_on) output_on <= 1'b0;
      else if ((PANEL_ONOFF && onoff_ok) || OUTPUT_ON_REQ) begin
        if (!(|(alarm_latch & no_ot)) && !ot_block) output_on <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Front-panel lock
  // ---------------------------------------------------------------
  wire attempt = PANEL_CHANGE || (PANEL_ONOFF && !ctrl[CTRL_LOCK_ONOFF]);
  wire pin_write = wr_ok && wr_addr == OFS_PIN_ENTRY;
  assign pin_ok = pin_write && wr_data[15:0] == pin_code;
  lock_state_type next_lock;
  always_comb begin
    next_lock = lock_state;
    case (lock_state)
      LK_OPEN: if (ctrl[CTRL_LOCK_EN]) next_lock = LK_LOCKED;
      LK_LOCKED: if (attempt) next_lock = LK_REQUEST; // see RL19
      LK_REQUEST: begin
        if (PANEL_CONFIRM) next_lock = ctrl[CTRL_PIN_EN] ? LK_PIN_WAIT : LK_OPEN; // see RL22
        else if (unlock_timer == '0) next_lock = LK_LOCKED; // see RL21
      end
      LK_PIN_WAIT: if (pin_ok) next_lock = LK_OPEN; // see RL22
      default: next_lock = LK_OPEN;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      lock_state <= LK_OPEN;
      unlock_timer <= '0;
    end else begin
      lock_state <= next_lock;
      if (lock_state == LK_LOCKED) unlock_timer <= TMR_W'(UNLOCK_TICKS - 1); // see RL26
      else if (unlock_timer != '0) unlock_timer <= unlock_timer - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      OUTPUT_ENABLE <= 1'b0;
      PANEL_ACCEPT <= 1'b0;
      PANEL_ONOFF_ACCEPT <= 1'b0;
      UNLOCK_REQUEST <= 1'b0;
      PIN_REQUEST <= 1'b0;
      ALARM_NOTICE <= 1'b0;
      WARNING_NOTICE <= 1'b0;
      SOUND <= 1'b0;
      ALARM_FLAGS <= '0;
      EVENT_FLAGS <= '0;
      ANALOG_ALARMS <= '0;
    end else begin
      OUTPUT_ENABLE <= output_on;
      PANEL_ACCEPT <= next_lock == LK_OPEN; // see RL19
      PANEL_ONOFF_ACCEPT <= onoff_ok;
      UNLOCK_REQUEST <= next_lock == LK_REQUEST;
      PIN_REQUEST <= next_lock == LK_PIN_WAIT;
      ALARM_NOTICE <= alarm_pop;
      WARNING_NOTICE <= warn_pop;
      SOUND <= alarm_pop && ctrl[CTRL_SOUND]; // see RL18
      ALARM_FLAGS <= alarm_latch | alarm_seen;
      EVENT_FLAGS <= event_latch; // see RL24
      // Parallel alarm is not reported on the analog side
      ANALOG_ALARMS <= {alarm_latch[ALM_OT], alarm_latch[ALM_SUPPLY],
        |alarm_latch[ALM_OPP:ALM_OVP]}; // see RL3
    end
  end
endmodule

// ==== verif/alarm_event_monitor_properties.sv ====
// Port-level checks of the alarm and event monitor.
`timescale 1ns/1ps
module alarm_event_monitor_properties
  import alarm_pkg::*;
#(
  parameter int UNLOCK_TICKS = 20
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic S_AXI_BVALID,
  input wire logic OUTPUT_ENABLE,
  input wire logic SUPPLY_FAIL,
  input wire logic PARALLEL_REINIT,
  input wire logic PANEL_CHANGE,
  input wire logic PANEL_ONOFF,
  input wire logic PANEL_ACK,
  input wire logic PANEL_ACCEPT,
  input wire logic UNLOCK_REQUEST,
  input wire logic ALARM_NOTICE,
  input wire logic SOUND,
  input wire logic [NUM_ALM-1:0] ALARM_FLAGS,
  input wire logic [NUM_EVT-1:0] EVENT_FLAGS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Panel acknowledge or any register write response
  wire ack_now = PANEL_ACK | S_AXI_BVALID;
  wire attempt = PANEL_CHANGE | PANEL_ONOFF;
  logic [3:0] ack_hist;
  int req_len;
  always_ff @(posedge REF_CLK) begin
    ack_hist <= RST ? 4'h0 : {ack_hist[2:0], ack_now};
    req_len <= (RST || !UNLOCK_REQUEST) ? 0 : req_len + 1;
  end
  a_trip_output_off: assert property (
    $rose(ALARM_FLAGS[ALM_OCP]) |-> ##[0:1] !OUTPUT_ENABLE) else $error("trip left output on");
  a_supply_flagged: assert property (
    SUPPLY_FAIL |-> ##[1:2] ALARM_FLAGS[ALM_SUPPLY]) else $error("supply not flagged");
  a_latch_held: assert property (
    ALARM_FLAGS[ALM_OCP] && ack_hist == 4'h0 && !ack_now |=> ALARM_FLAGS[ALM_OCP])
    else $error("latch lost");
  a_event_gated: assert property (
    |(EVENT_FLAGS & ~$past(EVENT_FLAGS)) |->
      $past(OUTPUT_ENABLE) || $past(OUTPUT_ENABLE, 2) || $past(OUTPUT_ENABLE, 3))
    else $error("event while off");
  a_sound_gate: assert property (
    SOUND |-> ALARM_NOTICE) else $error("lone sound");
  a_locked_reject: assert property (
    UNLOCK_REQUEST |-> !PANEL_ACCEPT) else $error("accept while locked");
  a_request_cause: assert property (
    $rose(UNLOCK_REQUEST) |-> $past(attempt) || $past(attempt, 2) || $past(attempt, 3))
    else $error("request uncaused");
  a_request_expiry: assert property (
    req_len <= UNLOCK_TICKS + 4) else $error("request kept");
  a_link_clear: assert property (
    $fell(ALARM_FLAGS[ALM_PAR]) |->
      $past(PARALLEL_REINIT) || $past(PARALLEL_REINIT, 2) || $past(PARALLEL_REINIT, 3))
    else $error("link alarm cleared");
  c_unlock: cover property ($rose(UNLOCK_REQUEST));
  c_event: cover property ($rose(|EVENT_FLAGS));
  c_trip: cover property ($rose(ALARM_FLAGS[ALM_OCP]));
endmodule

// ==== verif/panel_operator.sv ====
// Front panel operator: registers bench taps onto the panel inputs one cycle later.
`timescale 1ns/1ps
module panel_operator (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] tap,
  output logic [4:0] press
);
  // Bench times the confirm tap
  always_ff @(posedge clk) begin
    press <= rst ? 5'h00 : tap;
  end
endmodule

// ==== verif/alarm_event_monitor_test.sv ====
// Self-checking bench for the alarm and event monitor.
`timescale 1ns/1ps
module alarm_event_monitor_test;
  import alarm_pkg::*;
  localparam int TICKS = 20;
  logic clk = 1'b0, rst = 1'b1, aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
  logic ar_valid = 1'b0, r_ready = 1'b0, supply_fail = 1'b0;
  logic slave_lost = 1'b0, reinit = 1'b0;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0, r_data;
  logic [5:0] taps = 6'h00;
  logic [4:0] press, event_flags;
  wire on_req = taps[5];
  meas_type meas = '0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, out_en, accept, onoff_ok;
  logic unlock_req, pin_req, alarm_note, warn_note, sound;
  logic [1:0] b_resp, r_resp;
  logic [5:0] alarm_flags;
  logic [2:0] analog;
  int fail_count = 0, checked = 0, k;
  initial forever #4 clk = ~clk;
  alarm_event_monitor #(.UNLOCK_TICKS(TICKS)) alarm_event_monitor_i (
    .REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
    .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .MEAS(meas),
    .OUTPUT_ON_REQ(on_req), .SUPPLY_FAIL(supply_fail), .TEMP_LIMIT(1'b0),
    .SLAVE_LOST(slave_lost), .PARALLEL_REINIT(reinit), .OUTPUT_ENABLE(out_en),
    .PANEL_CHANGE(press[0]), .PANEL_ONOFF(press[1]), .PANEL_CONFIRM(press[2]),
    .PANEL_STATUS_TAP(press[3]), .PANEL_ACK(press[4]), .PANEL_ACCEPT(accept),
    .PANEL_ONOFF_ACCEPT(onoff_ok), .UNLOCK_REQUEST(unlock_req), .PIN_REQUEST(pin_req),
    .ALARM_NOTICE(alarm_note), .WARNING_NOTICE(warn_note), .SOUND(sound),
    .ALARM_FLAGS(alarm_flags), .EVENT_FLAGS(event_flags), .ANALOG_ALARMS(analog));
  panel_operator panel_operator_i (.clk(clk), .rst(rst), .tap(taps[4:0]), .press(press));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw_ready) aw_valid <= 1'b0;
      if (w_ready) w_valid <= 1'b0;
    end while (!b_valid && n < 40);
    b_ready <= 1'b0;
    if (!b_valid) begin
      fail_count++;
      summarize();
    end
    chk("bresp", 32'(RESP_OKAY), 32'(b_resp));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge clk);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (ar_ready) ar_valid <= 1'b0;
    end while (!r_valid && n < 40);
    r_ready <= 1'b0;
    if (!r_valid) begin
      fail_count++;
      summarize();
    end
    chk("rresp", 32'(er), 32'(r_resp));
    chk("rdata", e, r_data);
  endtask
  // Index 5 is the remote output-on request
  task automatic tap(input int i);
    @(posedge clk);
    taps <= 6'h01 << i;
    @(posedge clk);
    taps <= 6'h00;
    cyc(4);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    cyc(8);
    rst <= 1'b0;
    for (k = 0; k < 3; k++) rc(OFS_OVP_LIM + 8'(4 * k), 32'h0000FFFF, RESP_OKAY);
    for (k = 0; k < NUM_EVT; k++) begin
      rc(OFS_EVT_BASE + 8'(4 * k), 32'h0, RESP_OKAY);
      chk("action", 32'(ACT_NONE), 32'(r_data[17:16]));
      wr(OFS_EVT_BASE + 8'(4 * k), {14'h0, ACT_SIGNAL, 16'h4000});
    end
    rc(8'h3C, 32'h0, RESP_SLVERR);
    meas <= {3{16'h8000}};
    cyc(4);
    chk("off events", 32'h0, 32'(event_flags));
    tap(5);
    chk("high events", 32'h1A, 32'(event_flags));
    chk("out_en", 32'h1, 32'(out_en));
    meas <= '0;
    cyc(4);
    chk("low events", 32'h1F, 32'(event_flags));
    for (k = 2; k < 5; k++) begin
      // Sound on middle pass only
      wr(OFS_CTRL, 32'(k == 3));
      wr(OFS_EVT_BASE + 8'h0C, {14'h0, (k == 2) ? ACT_WARNING : ACT_ALARM, 16'h4000});
      tap(4);
      meas <= {16'h0, 16'h8000, 16'h0};
      cyc(4);
      chk("warn_note", 32'(k == 2), 32'(warn_note));
      chk("out_en", 32'(k == 2), 32'(out_en));
      chk("sound", 32'(k == 3), 32'(sound));
      meas <= '0;
      tap(5);
    end
    wr(OFS_OCP_LIM, 32'h00001000);
    wr(OFS_OPP_LIM, 32'h00001000);
    tap(4);
    meas <= {16'h0, 16'h1000, 16'h1000};
    cyc(4);
    chk("flags", 32'h06, 32'(alarm_flags));
    chk("out_en", 32'h0, 32'(out_en));
    chk("analog", 32'h1, 32'(analog));
    meas <= '0;
    cyc(4);
    chk("flags", 32'h06, 32'(alarm_flags));
    tap(4);
    chk("flags", 32'h00, 32'(alarm_flags));
    supply_fail <= 1'b1;
    cyc(4);
    tap(4);
    chk("flags", 32'h08, 32'(alarm_flags));
    chk("alarm_note", 32'h0, 32'(alarm_note));
    tap(3);
    chk("alarm_note", 32'h1, 32'(alarm_note));
    supply_fail <= 1'b0;
    slave_lost <= 1'b1;
    tap(4);
    slave_lost <= 1'b0;
    tap(4);
    chk("flags", 32'h20, 32'(alarm_flags));
    chk("analog", 32'h0, 32'(analog));
    reinit <= 1'b1;
    @(posedge clk);
    reinit <= 1'b0;
    cyc(4);
    chk("flags", 32'h00, 32'(alarm_flags));
    wr(OFS_PIN, 32'h00001234);
    wr(OFS_CTRL, 32'h14);
    cyc(4);
    chk("accept", 32'h0, 32'(accept));
    chk("onoff_ok", 32'h0, 32'(onoff_ok));
    tap(0);
    chk("unlock_req", 32'h1, 32'(unlock_req));
    cyc(TICKS + 4);
    chk("unlock_req", 32'h0, 32'(unlock_req));
    rc(OFS_LOCK_STAT, 32'h1, RESP_OKAY);
    tap(0);
    tap(2);
    chk("pin_req", 32'h1, 32'(pin_req));
    wr(OFS_PIN_ENTRY, 32'h00001111);
    cyc(4);
    chk("pin_req", 32'h1, 32'(pin_req));
    wr(OFS_PIN_ENTRY, 32'h00001234);
    cyc(4);
    chk("pin_req", 32'h0, 32'(pin_req));
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule
bind alarm_event_monitor alarm_event_monitor_properties #(.UNLOCK_TICKS(UNLOCK_TICKS))
  alarm_event_monitor_properties_i (.*);
